// ---- rtl/bsb_boot_ctrl.sv ----
// Boot bring-up sequencer with Avalon-MM control registers
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`default_nettype none
`include "bsb_consts.svh"
module bsb_boot_ctrl #(
	parameter int unsigned WD_CYCLES = `BSB_WD_MIN_MS * `BSB_CLK_KHZ
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	// Avalon-MM slave
	input  wire bsb_pkg::bsb_avreq_s avReq,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	// Reset pins, straps and fuses
	input  wire logic              coldRstPin_n,
	input  wire logic              warmRstPin_n,
	input  wire logic [2:0]        boot_select_pins,
	input  wire logic [1:0]        clock_select_pins,
	input  wire logic              fabricBootFuse,
	input  wire logic              oscExtFuse,
	input  wire logic              authFuse,
	input  wire logic              decryptFuse,
	// Crypto engine handshake
	input  wire logic              authDone,
	input  wire logic              decryptDone,
	output logic                   authStart,
	output logic                   decryptStart,
	// Core and memory control
	output logic                   secondaryCoreHold,
	output logic                   bootRomEnable,
	output logic                   ramTopReserved,
	// Boot source and clocks
	output bsb_pkg::bsb_src_e      bootSource,
	output logic                   fabricBoot,
	output logic                   bootError,
	output logic                   pllConfigure,
	output logic                   pllRefExternal,
	output logic [1:0]             pllClockSel,
	// Dedicated boot I/O
	output logic                   ioMuxApply,
	output logic                   ioPadApply,
	output bsb_pkg::bsb_iotype_e   ioMuxSel,
	output logic [14:0]            ioDirection,
	// Security and watchdog
	output bsb_pkg::bsb_sec_e      securityLevel,
	output logic                   bootWdExpired
);
	import bsb_pkg::*;

	localparam int unsigned NSYNC = 11;

	// Pin synchroniser: first stage read only by the second
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_reg <= 11'h000;
			sync2_reg <= 11'h000;
		end else begin
			sync1_reg <= {coldRstPin_n, warmRstPin_n, boot_select_pins,
				clock_select_pins, fabricBootFuse, oscExtFuse, authFuse, decryptFuse};
			sync2_reg <= sync1_reg;
		end
	end

	logic       coldN;
	logic       warmN;
	logic [2:0] bselS;
	logic [1:0] cselS;
	logic       fuseFab;
	logic       fuseOsc;
	logic       fuseAuth;
	logic       fuseDec;
	assign {coldN, warmN, bselS, cselS, fuseFab, fuseOsc, fuseAuth, fuseDec} = sync2_reg;

	// Per-type direction table, one entry per dedicated I/O
	logic [14:0] dirNand;
	logic [14:0] dirSd;
	logic [14:0] dirQspi;
	logic [14:0] dirSel;
	logic [1:0]  ioTypeNow;
	assign dirNand = `BSB_DIR_NAND;
	assign dirSd   = `BSB_DIR_SDMMC;
	assign dirQspi = `BSB_DIR_QSPI;
	genvar gi;
	generate
		for (gi = 0; gi < `BSB_IO_COUNT; gi++) begin : g_io
			assign dirSel[gi] = (ioTypeNow == IO_NAND)  ? dirNand[gi] :
			                    (ioTypeNow == IO_SDMMC) ? dirSd[gi] : dirQspi[gi];
		end
	endgenerate

	// State
	bsb_state_e  state_reg,   state_next;
	bsb_src_e    src_reg,     src_next;
	logic        warm_reg,    warm_next;
	logic [3:0]  ctrl_reg,    ctrl_next;
	logic [2:0]  hdr_reg,     hdr_next;
	logic        romEn_reg,   romEn_next;
	logic        secHold_reg, secHold_next;
	logic        ramRsv_reg,  ramRsv_next;
	logic        fab_reg,     fab_next;
	logic        err_reg,     err_next;
	logic        pllCfg_reg,  pllCfg_next;
	logic        pllExt_reg,  pllExt_next;
	logic [1:0]  pllSel_reg,  pllSel_next;
	logic        muxAp_reg,   muxAp_next;
	logic        padAp_reg,   padAp_next;
	logic [1:0]  ioSel_reg,   ioSel_next;
	logic [14:0] ioDir_reg,   ioDir_next;
	logic [1:0]  secLvl_reg,  secLvl_next;
	logic        authPend_reg, authPend_next;
	logic        decPend_reg, decPend_next;
	logic        busy_reg,    busy_next;
	logic        authSt_reg,  authSt_next;
	logic        decSt_reg,   decSt_next;
	logic        wdRun_reg,   wdRun_next;
	logic [31:0] wdCnt_reg,   wdCnt_next;
	logic [31:0] wdLim_reg,   wdLim_next;
	logic        wdExp_reg,   wdExp_next;
	logic        wait_reg,    wait_next;
	logic [31:0] rdata_reg,   rdata_next;
	logic        warmPrev_reg, warmPrev_next;

	logic        wrAck;
	logic        wrCtrl;
	logic        swWarm;
	logic        wdKick;
	logic        wdClr;
	logic        warmEvt;
	logic [1:0]  secMerged;
	logic [1:0]  iotypeOf;

	// Write takes effect on the edge where waitrequest is seen low
	assign wrAck   = avReq.write && !wait_reg;
	assign wrCtrl  = wrAck && (avReq.address == `BSB_OFS_CTRL);
	assign swWarm  = wrCtrl && avReq.writedata[`BSB_CTRL_SWWARM];
	assign wdKick  = wrCtrl && avReq.writedata[`BSB_CTRL_WDKICK];
	assign wdClr   = wrCtrl && avReq.writedata[`BSB_CTRL_WDCLR];
	// warm from pin falling edge or software request
	assign warmEvt = (warmPrev_reg && !warmN) || swWarm;
	// fuse data merged with an optional header
	assign secMerged = {fuseDec, fuseAuth} |
		(hdr_reg[`BSB_HDR_VALID] ? {hdr_reg[`BSB_HDR_DEC], hdr_reg[`BSB_HDR_AUTH]} : 2'h0);
	// Flash type from the chosen source
	assign iotypeOf = (src_reg[2:1] == 2'h1) ? IO_NAND :
	                  (src_reg[2:1] == 2'h2) ? IO_SDMMC : IO_QSPI;
	assign ioTypeNow = iotypeOf;

	// Sequencer, registers and watchdog next values
	always_comb begin
		state_next    = state_reg;
		src_next      = src_reg;
		warm_next     = warm_reg;
		ctrl_next     = ctrl_reg;
		hdr_next      = hdr_reg;
		romEn_next    = romEn_reg;
		secHold_next  = secHold_reg;
		ramRsv_next   = ramRsv_reg;
		fab_next      = fab_reg;
		err_next      = err_reg;
		pllCfg_next   = 1'b0;
		pllExt_next   = pllExt_reg;
		pllSel_next   = pllSel_reg;
		muxAp_next    = 1'b0;
		padAp_next    = 1'b0;
		ioSel_next    = ioSel_reg;
		ioDir_next    = ioDir_reg;
		secLvl_next   = secLvl_reg;
		authPend_next = authPend_reg;
		decPend_next  = decPend_reg;
		busy_next     = busy_reg;
		authSt_next   = 1'b0;
		decSt_next    = 1'b0;
		wdRun_next    = wdRun_reg;
		wdCnt_next    = wdCnt_reg;
		wdLim_next    = wdLim_reg;
		wdExp_next    = wdExp_reg;
		warmPrev_next = warmN;
		wait_next     = 1'b1;
		rdata_next    = rdata_reg;

		// Bus: one ready cycle per request, read data set with it
		if ((avReq.read || avReq.write) && wait_reg) begin
			wait_next = 1'b0;
			case (avReq.address)
				`BSB_OFS_CTRL: rdata_next = {28'h0000000, ctrl_reg};
				`BSB_OFS_HDR:  rdata_next = {29'h00000000, hdr_reg};
				`BSB_OFS_STAT: rdata_next = {18'h00000, ioSel_reg, secLvl_reg, wdExp_reg,
					err_reg, warm_reg, fab_reg, state_reg, src_reg};
				default:       rdata_next = 32'h00000000;
			endcase
		end
		if (wrCtrl) begin
			ctrl_next[`BSB_CTRL_RETMUX] = avReq.writedata[`BSB_CTRL_RETMUX];
			ctrl_next[`BSB_CTRL_RETIO]  = avReq.writedata[`BSB_CTRL_RETIO];
			ctrl_next[`BSB_CTRL_RELSEC] = avReq.writedata[`BSB_CTRL_RELSEC];
		end
		if (wrAck && avReq.address == `BSB_OFS_HDR) begin
			hdr_next = avReq.writedata[2:0];
		end

		// Watchdog runs until expiry; software kick restarts it
		if (wdRun_reg) begin
			if (wdKick) begin
				wdCnt_next = 32'h00000000;
			end else if (wdCnt_reg >= wdLim_reg) begin
				wdRun_next = 1'b0;
			end else begin
				wdCnt_next = wdCnt_reg + 32'h00000001;
			end
		end
		// Expiry flag: set wins over a clear in the same cycle
		if (wdRun_reg && !wdKick && wdCnt_reg >= wdLim_reg) begin
			wdExp_next = 1'b1;
		end else if (wdClr) begin
			wdExp_next = 1'b0;
		end

		// release honoured only once ROM is off
		if (!romEn_reg && ctrl_reg[`BSB_CTRL_RELSEC]) begin
			secHold_next = 1'b0;
		end

		case (state_reg)
			ST_HOLD: begin
				if (warmN) begin
					state_next = ST_SELECT;
				end
			end
			ST_SELECT: begin
				// arm watchdog early, longer unless bypassed or fabric fuse blown
				wdRun_next = 1'b1;
				wdCnt_next = 32'h00000000;
				// a blown fabric fuse ignores the clock-select pins here too
				wdLim_next = (fuseFab || cselS == `BSB_CLOCK_SELECT_PINS_BYPASS) ? WD_CYCLES : (WD_CYCLES << 1);
				if (fuseFab) begin
					src_next = SRC_FABRIC;
				end else begin
					src_next = bsb_src_e'(bselS);
				end
				fab_next = fuseFab || (bselS == SRC_FABRIC);
				if (!fuseFab && bselS == SRC_RSVD) begin
					err_next   = 1'b1;
					state_next = ST_FAULT;
				end else begin
					err_next   = 1'b0;
					// reserve only on cold flash boot
					ramRsv_next = !warm_reg && !(fuseFab || bselS == SRC_FABRIC);
					state_next = ST_CLOCKS;
				end
			end
			ST_CLOCKS: begin
				// one reference for both PLLs from fuse
				pllExt_next = fuseOsc;
				// set PLLs unless warm, fabric or bypass
				if (!fab_reg && !warm_reg && cselS != `BSB_CLOCK_SELECT_PINS_BYPASS) begin
					pllCfg_next = 1'b1;
					pllSel_next = cselS;
				end
				state_next = ST_IOCFG;
			end
			ST_IOCFG: begin
				// fabric boot leaves boot I/Os alone
				if (!fab_reg) begin
					// mux kept on warm with retain bit
					if (!(warm_reg && ctrl_reg[`BSB_CTRL_RETMUX])) begin
						muxAp_next = 1'b1;
						ioSel_next = iotypeOf;
					end
					// pads kept on warm with retain bit
					if (!(warm_reg && ctrl_reg[`BSB_CTRL_RETIO])) begin
						padAp_next = 1'b1;
						ioDir_next = dirSel;
					end
				end
				secLvl_next   = secMerged;
				authPend_next = secMerged[0];
				decPend_next  = secMerged[1];
				busy_next     = 1'b0;
				state_next    = ST_SECURE;
			end
			ST_SECURE: begin
				if (authPend_reg) begin
					if (!busy_reg) begin
						authSt_next = 1'b1;
						busy_next   = 1'b1;
					end else if (authDone) begin
						authPend_next = 1'b0;
						busy_next     = 1'b0;
					end
				end else if (decPend_reg) begin
					if (!busy_reg) begin
						decSt_next = 1'b1;
						busy_next  = 1'b1;
					end else if (decryptDone) begin
						decPend_next = 1'b0;
						busy_next    = 1'b0;
					end
				end else begin
					state_next = ST_HANDOFF;
				end
			end
			ST_HANDOFF: begin
				wdCnt_next  = 32'h00000000;
				// boot ROM closed as user code starts
				romEn_next  = 1'b0;
				ramRsv_next = 1'b0;
				state_next  = ST_USER;
			end
			ST_USER: begin
				state_next = ST_USER;
			end
			ST_FAULT: begin
				state_next = ST_FAULT;
			end
			default: begin
				state_next = ST_HOLD;
			end
		endcase

		// warm reset keeps retain bits and header
		if (warmEvt || !warmN) begin
			state_next   = ST_HOLD;
			warm_next    = 1'b1;
			// secondary held while ROM code runs
			romEn_next   = 1'b1;
			secHold_next = 1'b1;
			ramRsv_next  = 1'b0;
			wdRun_next   = 1'b0;
			ctrl_next[`BSB_CTRL_RELSEC] = 1'b0;
		end
		if (!coldN) begin
			state_next   = ST_HOLD;
			warm_next    = 1'b0;
			ctrl_next    = `BSB_CTRL_RST;
			hdr_next     = `BSB_HDR_RST;
			romEn_next   = 1'b1;
			secHold_next = 1'b1;
			ramRsv_next  = 1'b0;
			wdRun_next   = 1'b0;
			err_next     = 1'b0;
		end
	end

	// Register stage
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= ST_HOLD;
			src_reg      <= SRC_RSVD;
			warm_reg     <= 1'b0;
			ctrl_reg     <= `BSB_CTRL_RST;
			hdr_reg      <= `BSB_HDR_RST;
			romEn_reg    <= 1'b1;
			secHold_reg  <= 1'b1;
			ramRsv_reg   <= 1'b0;
			fab_reg      <= 1'b0;
			err_reg      <= 1'b0;
			pllCfg_reg   <= 1'b0;
			pllExt_reg   <= 1'b0;
			pllSel_reg   <= 2'h0;
			muxAp_reg    <= 1'b0;
			padAp_reg    <= 1'b0;
			ioSel_reg    <= 2'h0;
			ioDir_reg    <= 15'h0000;
			secLvl_reg   <= 2'h0;
			authPend_reg <= 1'b0;
			decPend_reg  <= 1'b0;
			busy_reg     <= 1'b0;
			authSt_reg   <= 1'b0;
			decSt_reg    <= 1'b0;
			wdRun_reg    <= 1'b0;
			wdCnt_reg    <= 32'h00000000;
			wdLim_reg    <= 32'h00000000;
			wdExp_reg    <= 1'b0;
			wait_reg     <= 1'b1;
			rdata_reg    <= 32'h00000000;
			warmPrev_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			src_reg      <= src_next;
			warm_reg     <= warm_next;
			ctrl_reg     <= ctrl_next;
			hdr_reg      <= hdr_next;
			romEn_reg    <= romEn_next;
			secHold_reg  <= secHold_next;
			ramRsv_reg   <= ramRsv_next;
			fab_reg      <= fab_next;
			err_reg      <= err_next;
			pllCfg_reg   <= pllCfg_next;
			pllExt_reg   <= pllExt_next;
			pllSel_reg   <= pllSel_next;
			muxAp_reg    <= muxAp_next;
			padAp_reg    <= padAp_next;
			ioSel_reg    <= ioSel_next;
			ioDir_reg    <= ioDir_next;
			secLvl_reg   <= secLvl_next;
			authPend_reg <= authPend_next;
			decPend_reg  <= decPend_next;
			busy_reg     <= busy_next;
			authSt_reg   <= authSt_next;
			decSt_reg    <= decSt_next;
			wdRun_reg    <= wdRun_next;
			wdCnt_reg    <= wdCnt_next;
			wdLim_reg    <= wdLim_next;
			wdExp_reg    <= wdExp_next;
			wait_reg     <= wait_next;
			rdata_reg    <= rdata_next;
			warmPrev_reg <= warmPrev_next;
		end
	end

	// Outputs straight from flops
	assign readdata          = rdata_reg;
	assign waitrequest       = wait_reg;
	assign authStart         = authSt_reg;
	assign decryptStart      = decSt_reg;
	assign secondaryCoreHold = secHold_reg;
	assign bootRomEnable     = romEn_reg;
	assign ramTopReserved    = ramRsv_reg;
	assign bootSource        = src_reg;
	assign fabricBoot        = fab_reg;
	assign bootError         = err_reg;
	assign pllConfigure      = pllCfg_reg;
	assign pllRefExternal    = pllExt_reg;
	assign pllClockSel       = pllSel_reg;
	assign ioMuxApply        = muxAp_reg;
	assign ioPadApply        = padAp_reg;
	assign ioMuxSel          = bsb_iotype_e'(ioSel_reg);
	assign ioDirection       = ioDir_reg;
	assign securityLevel     = bsb_sec_e'(secLvl_reg);
	assign bootWdExpired     = wdExp_reg;

	// Checks
	chk_sec_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!secHold_reg |-> !romEn_reg) else $error("secondary core out while ROM on");
	chk_rom_closed: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_reg == ST_HANDOFF && coldN && warmN && !swWarm |=> !romEn_reg && state_reg == ST_USER)
		else $error("ROM not closed");
	chk_fuse_fabric: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_reg == ST_SELECT && fuseFab && coldN && warmN && !swWarm |=> src_reg == SRC_FABRIC && fab_reg)
		else $error("fuse did not force fabric");
	chk_rsvd_code: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_reg == ST_SELECT && !fuseFab && bselS == 3'h0 && coldN && warmN && !swWarm
		|=> state_reg == ST_FAULT && err_reg) else $error("reserved code not flagged");
	chk_pll_skip: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pllCfg_reg |-> !warm_reg && !fab_reg && pllSel_reg != `BSB_CLOCK_SELECT_PINS_BYPASS) else $error("PLL set wrongly");
	chk_io_fabric: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(muxAp_reg || padAp_reg) |-> !fab_reg) else $error("I/O set on fabric boot");
	chk_auth_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
		decSt_reg |-> !authPend_reg && $past(state_reg) == ST_SECURE) else $error("decrypt before auth");
	chk_ram_free: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ramRsv_reg |-> !warm_reg && !fab_reg && romEn_reg) else $error("RAM reserved wrongly");
	chk_wd_restart: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state_reg == ST_HANDOFF && wdRun_reg |=> wdCnt_reg <= 32'h00000001) else $error("watchdog not restarted");
	chk_bus_ready: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!wait_reg |=> wait_reg) else $error("waitrequest low twice");
endmodule
`default_nettype wire

// ---- rtl/bsb_consts.svh ----
// Offsets, field positions, reset values and timing counts of boot bring-up control
`ifndef BSB_CONSTS_SVH
`define BSB_CONSTS_SVH
// Register byte offsets
`define BSB_OFS_CTRL        4'h0
`define BSB_OFS_HDR         4'h4
`define BSB_OFS_STAT        4'h8
// Control register fields
`define BSB_CTRL_RETMUX     0
`define BSB_CTRL_RETIO      1
`define BSB_CTRL_SWWARM     2
`define BSB_CTRL_RELSEC     3
`define BSB_CTRL_WDKICK     4
`define BSB_CTRL_WDCLR      5
`define BSB_CTRL_RST        4'h0
// Header register fields
`define BSB_HDR_VALID       0
`define BSB_HDR_AUTH        1
`define BSB_HDR_DEC         2
`define BSB_HDR_RST         3'h0
// Clock select code that means PLL bypass
`define BSB_CLOCK_SELECT_PINS_BYPASS     2'h0
// Dedicated boot I/O count and per-type direction tables (1 = output)
`define BSB_IO_COUNT        15
`define BSB_DIR_NAND        15'h3f0f
`define BSB_DIR_SDMMC       15'h0103
`define BSB_DIR_QSPI        15'h000b
// Top 4 KB of on-chip RAM held as boot workspace
`define BSB_RAM_RSV_KB      4
// Watchdog: least timeout and clock rate
`define BSB_WD_MIN_MS       1000
`define BSB_CLK_KHZ         125000
`endif

// ---- rtl/bsb_pkg.sv ----
// Types shared by boot bring-up control
`default_nettype none
package bsb_pkg;
	typedef enum logic [2:0] {
		ST_HOLD    = 3'h0,
		ST_SELECT  = 3'h1,
		ST_CLOCKS  = 3'h2,
		ST_IOCFG   = 3'h3,
		ST_SECURE  = 3'h4,
		ST_HANDOFF = 3'h5,
		ST_USER    = 3'h6,
		ST_FAULT   = 3'h7
	} bsb_state_e;
	typedef enum logic [2:0] {
		SRC_RSVD     = 3'h0,
		SRC_FABRIC   = 3'h1,
		SRC_NAND18   = 3'h2,
		SRC_NAND30   = 3'h3,
		SRC_SDMMC18X = 3'h4,
		SRC_SDMMC30I = 3'h5,
		SRC_QSPI18   = 3'h6,
		SRC_QSPI30   = 3'h7
	} bsb_src_e;
	typedef enum logic [1:0] {
		SEC_CLEAR = 2'h0,
		SEC_AUTH  = 2'h1,
		SEC_DEC   = 2'h2,
		SEC_BOTH  = 2'h3
	} bsb_sec_e;
	typedef enum logic [1:0] {
		IO_NAND  = 2'h0,
		IO_SDMMC = 2'h1,
		IO_QSPI  = 2'h2
	} bsb_iotype_e;
	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} bsb_avreq_s;
endpackage
`default_nettype wire

// ---- testbench/bsb_crypto_model.sv ----
// Crypto engine model answering the sequencer's start pulses after a random delay
`default_nettype none
module bsb_crypto_model (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic reset_n,
	// Start pulses from the sequencer
	input  wire logic authStart,
	input  wire logic decryptStart,
	// Completion pulses back to the sequencer
	output logic      authDone,
	output logic      decryptDone
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [4:0] authCnt;
	logic [4:0] decCnt;

	// separate engines; done is a single pulse, so a stale level never lingers
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			authCnt <= 5'h00;
			decCnt <= 5'h00;
			authDone <= 1'b0;
			decryptDone <= 1'b0;
		end else begin
			authDone <= 1'b0;
			decryptDone <= 1'b0;
			if (authStart) begin
				authCnt <= 5'(1 + $urandom % 16);
			end else if (authCnt != 5'h00) begin
				authCnt <= authCnt - 5'h01;
				authDone <= (authCnt == 5'h01);
			end
			if (decryptStart) begin
				decCnt <= 5'(1 + $urandom % 16);
			end else if (decCnt != 5'h00) begin
				decCnt <= decCnt - 5'h01;
				decryptDone <= (decCnt == 5'h01);
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the boot bring-up sequencer
`default_nettype none
`include "bsb_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import bsb_pkg::*;

	localparam int WD = 50;
	logic        sys_clk, reset_n, waitrequest, coldRstPin_n, warmRstPin_n, fabricBootFuse, oscExtFuse;
	logic        authFuse, decryptFuse, authDone, decryptDone, authStart, decryptStart, secondaryCoreHold;
	logic        bootRomEnable, ramTopReserved, fabricBoot, bootError, pllConfigure, pllRefExternal;
	logic        ioMuxApply, ioPadApply, bootWdExpired, fuse, osc, af, df, hv, ha, hd;
	bsb_avreq_s  avReq;
	logic [31:0] readdata, rd, ctrl;
	logic [2:0]  boot_select_pins, bs;
	logic [1:0]  clock_select_pins, cs, pllClockSel, selSeen;
	logic [14:0] ioDirection;
	bsb_src_e    bootSource;
	bsb_iotype_e ioMuxSel;
	bsb_sec_e    securityLevel;
	int          bad_count, cmp_count, nPll, nMux, nPad, tAuth, tDec, ramSeen, holdBad, n, lim;
	int          cyc = 1;

	bsb_boot_ctrl #(.WD_CYCLES(WD)) dut (.sys_clk, .reset_n, .avReq, .readdata, .waitrequest, .coldRstPin_n,
		.warmRstPin_n, .boot_select_pins, .clock_select_pins, .fabricBootFuse, .oscExtFuse, .authFuse,
		.decryptFuse, .authDone, .decryptDone, .authStart, .decryptStart, .secondaryCoreHold, .bootRomEnable,
		.ramTopReserved, .bootSource, .fabricBoot, .bootError, .pllConfigure, .pllRefExternal, .pllClockSel,
		.ioMuxApply, .ioPadApply, .ioMuxSel, .ioDirection, .securityLevel, .bootWdExpired);
	bsb_crypto_model model (.sys_clk, .reset_n, .authStart, .decryptStart, .authDone, .decryptDone);

	// Clock, 8 ns period
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Pulse counters and start stamps; sees pre-edge values of registered outputs
	always @(posedge sys_clk) begin
		if (pllConfigure === 1'b1) begin
			nPll++;
			selSeen = pllClockSel;
		end
		nMux += (ioMuxApply === 1'b1);
		nPad += (ioPadApply === 1'b1);
		if (authStart === 1'b1) tAuth = cyc;
		if (decryptStart === 1'b1) tDec = cyc;
		if (ramTopReserved === 1'b1) ramSeen = 1;
		// secondary core never runs while the boot ROM is still reachable
		if (reset_n === 1'b1 && secondaryCoreHold !== 1'b1 && bootRomEnable !== 1'b0) holdBad++;
		cyc++;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wait_fail(input string nm);
		chk(nm, 32'h1, 32'h0);
		report_and_stop();
	endtask

	// One Avalon-MM transfer; waitrequest and read data are taken at the same rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge sys_clk);
		avReq <= '{address: a, read: !wr, write: wr, writedata: d};
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 64);
		if (k >= 64) wait_fail("bus wait");
		rd = readdata;
		avReq <= '0;
	endtask

	function automatic bsb_iotype_e exp_io(input logic [2:0] c);
		return (c < 3'h4) ? IO_NAND : (c < 3'h6) ? IO_SDMMC : IO_QSPI;
	endfunction

	// Pad direction table expected for each flash type
	function automatic logic [14:0] exp_dir(input bsb_iotype_e t);
		return (t == IO_NAND) ? `BSB_DIR_NAND : (t == IO_SDMMC) ? `BSB_DIR_SDMMC : `BSB_DIR_QSPI;
	endfunction

	task automatic straps(input logic [2:0] b, input logic f);
		@(posedge sys_clk);
		bs = b;
		cs = 2'($urandom);
		fuse = f;
		osc = 1'($urandom);
		af = 1'($urandom);
		df = 1'($urandom);
		boot_select_pins <= bs;
		clock_select_pins <= cs;
		fabricBootFuse <= fuse;
		oscExtFuse <= osc;
		authFuse <= af;
		decryptFuse <= df;
	endtask

	// Kind 0 cold pin, 1 software warm, 2 warm pin; returns three cycles after the ROM is seen closed or a fault is seen
	task automatic run_boot(input int kind);
		@(negedge sys_clk);
		nPll = 0;
		nMux = 0;
		nPad = 0;
		tAuth = 0;
		tDec = 0;
		ramSeen = 0;
		if (kind == 1) begin
			bus(1'b1, 4'h0, ctrl | 32'h4);
		end else begin
			@(posedge sys_clk);
			if (kind == 0) coldRstPin_n <= 1'b0;
			else warmRstPin_n <= 1'b0;
			repeat (6) @(posedge sys_clk);
			coldRstPin_n <= 1'b1;
			warmRstPin_n <= 1'b1;
		end
		if (kind == 0) {hv, ha, hd, ctrl} = '0;
		repeat (4) @(posedge sys_clk);
		n = 0;
		while (bootRomEnable !== 1'b0 && bootError !== 1'b1 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 500) wait_fail("boot wait");
		repeat (3) @(negedge sys_clk);
	endtask

	task automatic check(input logic warm);
		logic fab;
		logic err;
		logic [1:0] lvl;
		bsb_src_e src;
		err = !fuse && bs == 3'h0;
		fab = fuse || bs == 3'h1;
		src = bsb_src_e'(fuse ? 3'h1 : bs);
		lvl = {df | (hv & hd), af | (hv & ha)};
		chk("bootError", err, bootError);
		chk("secondary hold", 0, holdBad);
		if (err) begin
			chk("fault pll", 0, nPll + nMux);
			chk("fault rom", 1, bootRomEnable);
		end else begin
			chk("bootSource", src, bootSource);
			chk("fabricBoot", fab, fabricBoot);
			chk("pll count", !warm && !fab && cs != 2'h0, nPll);
			if (nPll == 1) chk("pll sel", cs, selSeen);
			chk("pll ref", osc, pllRefExternal);
			chk("mux count", !fab && !(warm && ctrl[0]), nMux);
			chk("pad count", !fab && !(warm && ctrl[1]), nPad);
			if (!fab) chk("mux type", exp_io(src), ioMuxSel);
			if (!fab) chk("io dir", exp_dir(exp_io(src)), ioDirection);
			chk("ram reserved", !warm && !fab, ramSeen);
			chk("ram freed", 0, ramTopReserved);
			chk("rom off", 0, bootRomEnable);
			chk("security", lvl, securityLevel);
			chk("auth run", lvl[0], tAuth != 0);
			chk("decrypt run", lvl[1], tDec != 0);
			if (lvl == 2'h3) chk("auth first", 1, tAuth < tDec);
			bus(1'b0, 4'h8, 32'h0);
			chk("status src", src, rd[2:0]);
			chk("status state", 6, rd[5:3]);
		end
	endtask

	initial begin
		reset_n = 1'b0;
		avReq = '0;
		coldRstPin_n = 1'b1;
		warmRstPin_n = 1'b1;
		{boot_select_pins, clock_select_pins, fabricBootFuse, oscExtFuse, authFuse, decryptFuse} = '0;
		void'($urandom(90840));
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl reset", 0, rd);
		bus(1'b0, 4'h4, 32'h0);
		chk("hdr reset", 0, rd);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped read", 0, rd);
		// Every boot-select code, then blown fuse, then random straps
		for (int i = 0; i < 20; i++) begin
			straps((i < 8) ? 3'(i) : 3'($urandom), 1'(i >= 8 && i < 12));
			run_boot(0);
			check(1'b0);
		end
		// Warm boots keep header and retain bits
		straps(3'h6, 1'b0);
		run_boot(0);
		check(1'b0);
		hv = 1'b1;
		ha = 1'($urandom);
		hd = 1'($urandom);
		bus(1'b1, 4'h4, {29'h0, hd, ha, hv});
		ctrl = 32'h3;
		bus(1'b1, 4'h0, ctrl);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl read", 3, rd);
		run_boot(1);
		check(1'b1);
		ctrl = 32'h0;
		bus(1'b1, 4'h0, ctrl);
		run_boot(2);
		check(1'b1);
		// Secondary core release after handoff, withdrawn by warm reset
		bus(1'b1, 4'h0, 32'h8);
		repeat (3) @(negedge sys_clk);
		chk("secondary released", 0, secondaryCoreHold);
		ctrl = 32'h8;
		run_boot(1);
		chk("secondary held again", 1, secondaryCoreHold);
		bus(1'b0, 4'h0, 32'h0);
		chk("release cleared", 0, rd[3:0]);
		// Boot watchdog: loader kick restarts it, then it runs out and software clears it
		run_boot(0);
		lim = (fuse || cs == 2'h0) ? WD : 2 * WD;
		repeat (20) @(posedge sys_clk);
		bus(1'b1, 4'h0, 32'h10);
		chk("wd before kick", 0, bootWdExpired);
		n = 0;
		while (bootWdExpired !== 1'b1 && n < lim + 20) begin
			@(negedge sys_clk);
			n++;
		end
		chk("wd expired", 1, bootWdExpired);
		chk("wd not early", 1, n >= lim);
		bus(1'b1, 4'h0, 32'h20);
		bus(1'b0, 4'h8, 32'h0);
		chk("wd cleared", 0, rd[9]);
		report_and_stop();
	end
endmodule
`default_nettype wire
